// ===== core/spr_ctrl.sv
/*
  Sleep mode sequencer, peripheral clock gating and software brown-out
  disable with AXI4-Lite register access. Assumes the clock tree holds a
  latch-based gate cell per enable and the interrupt logic runs on clk.
*/
// Local design decision: the AXI4-Lite slave port.
// Function
// R1: sleep mode field bits 6,4: 00 idle, 01 power-down, 10 standby, 11 power-down.
// R2: software picks standby only with an external crystal or resonator.
// R3: sleep instruction sleeps only while sleep enable bit is one.
// R4: software sets sleep enable just before sleeping, clears after wake.
// R5: gating register bits 7..4 read zero.
// R6: bit 3 freezes timer1 clock; clearing resumes it where it stopped.
// R7: bit 2 freezes timer0 clock; clearing resumes it.
// R8: bit 1 gates serial unit clock; software reinitialises it afterwards.
// R9: bit 0 gates uart clock; software reinitialises it afterwards.
// R10: brown-out sleep disable is set only through the enable-gated timed sequence.
// R11: software starts the sequence writing both bits one together.
// R12: within four cycles, disable one with enable zero is accepted.
// R13: disable bit active three cycles after set, cleared three later.
// R14: detector sleeps off only if sleep executes while disable is active.
// R15: comparator disabled automatically in every sleep mode but idle.
// R16: comparator using reference keeps reference on unless comparator disabled.
// R17: reference powered only when detector or comparator needs it.
// R18: fuse-enabled detector stays on in sleep unless software disable used.
// R19: enabled watchdog keeps running in every sleep mode.
// R20: input buffers off in sleep modes with the io clock stopped.
// R21: wake-up detecting input buffers stay enabled during sleep.
// R22: software keeps analog pins' digital buffers disabled.
// R23: interrupt wake halts cpu four cycles beyond start-up.
// R24: standby wakes within six cycles.
// R25: gated peripheral registers are not accessible and state is frozen.
// R26: detector re-enabled automatically on wake after software disable.
// R27: peripheral clock gating switches without glitches.
`include "spr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module spr_ctrl
  import spr_pkg::*;
#(
  parameter int PDOWN_START_CYC = `SPR_PDOWN_START_CYC,
  parameter int BOD_WAKE_CYC    = (`SPR_BOD_WAKE_NS + `SPR_CLK_NS - 1) / `SPR_CLK_NS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // cpu and interrupt side
  input  wire logic        sleep_instr,
  input  wire logic        wake_irq,
  output logic             cpu_halt,
  // analog and watchdog side
  input  wire logic        bod_fuse_pin,
  input  wire logic        acomp_disable,
  input  wire logic        acomp_use_ref,
  input  wire logic        wdt_enable,
  output logic             wdt_run,
  // power and clock controls
  output spr_pwr_t         pwr_ctrl,
  output spr_clk_t         clk_ctrl,
  output logic [3:0]       per_reg_access
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [2:0]  sleep_ctrl_ff;        // sm1, se, sm0
  logic [3:0]  pclk_gate_ff;
  logic        brownout_sleep_disable_ff;
  logic        brownout_sleep_disable_enable_ff;
  logic [2:0]  brownout_sleep_disable_enable_age_ff;
  logic [2:0]  brownout_sleep_disable_age_ff;
  logic        fuse_meta_ff;
  logic        fuse_sync_ff;
  spr_state_t  state_ff;
  spr_mode_t   mode_lat_ff;
  logic        bod_sw_off_ff;
  logic [15:0] cnt_ff;
  spr_pwr_t    pwr_ff;
  spr_clk_t    clk_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;

  spr_mode_t   cur_mode;
  logic        wr_take;
  logic        rd_take;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  wbyte;
  logic        brownout_sleep_disable_active;
  logic        deep_sleep;
  logic [15:0] start_cyc;
  logic [7:0]  rd_val;
  spr_pwr_t    nxt_pwr;
  spr_clk_t    nxt_clk;

  // mode field is split around the enable bit
  assign cur_mode = spr_mode_t'({sleep_ctrl_ff[2], sleep_ctrl_ff[0]}); // see R1

  // ------------------------------------------------------------
  // axi4-lite decode
  // ------------------------------------------------------------
  // both write channels are taken together, one answer outstanding
  assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign rd_take       = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
  assign wr_idx        = s_axi_awaddr[9:2];
  assign rd_idx        = s_axi_araddr[9:2];
  assign wbyte         = s_axi_wdata[7:0];
  assign wr_hit        = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr[31:10] == 22'h0)
                         && ((wr_idx == `SPR_IDX_SLEEP_CTRL) || (wr_idx == `SPR_IDX_PCLK_GATE)
                         || (wr_idx == `SPR_IDX_BOD_CTRL) || (wr_idx == `SPR_IDX_STATUS));
  assign rd_hit        = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[31:10] == 22'h0)
                         && ((rd_idx == `SPR_IDX_SLEEP_CTRL) || (rd_idx == `SPR_IDX_PCLK_GATE)
                         || (rd_idx == `SPR_IDX_BOD_CTRL) || (rd_idx == `SPR_IDX_STATUS));

  // write response, slverr on unmapped addresses
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
    end else if (wr_take) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read mux, unused bits read zero
  always_comb begin
    rd_val = 8'h00;
    case (rd_idx)
      `SPR_IDX_SLEEP_CTRL: rd_val = {1'b0, sleep_ctrl_ff, 4'h0};
      `SPR_IDX_PCLK_GATE:  rd_val = {4'h0, pclk_gate_ff};              // see R5
      `SPR_IDX_BOD_CTRL:   rd_val = {6'h00, brownout_sleep_disable_ff, brownout_sleep_disable_enable_ff};
      `SPR_IDX_STATUS:     rd_val = {1'b0, brownout_sleep_disable_active, bod_sw_off_ff, fuse_sync_ff,
                                     state_ff, mode_lat_ff};
      default:             rd_val = 8'h00;
    endcase
  end

  // read response
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= 2'h0;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_hit ? 2'h0 : 2'h2;
      rdata_ff  <= {24'h00_0000, rd_hit ? rd_val : 8'h00};
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // sleep control and clock gate bits, plain storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_ctrl_ff <= 3'h0;
      pclk_gate_ff  <= `SPR_RST_PCLK_GATE;
    end else if (wr_take && s_axi_wstrb[0]) begin
      if (wr_idx == `SPR_IDX_SLEEP_CTRL) begin
        sleep_ctrl_ff <= {wbyte[`SPR_SM1_BIT], wbyte[`SPR_SE_BIT], wbyte[`SPR_SM0_BIT]};
      end
      if (wr_idx == `SPR_IDX_PCLK_GATE) begin
        pclk_gate_ff <= wbyte[3:0];                                     // see R5
      end
    end
  end

  // enable bit opens a four-cycle window, then drops by itself
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brownout_sleep_disable_enable_ff     <= 1'b0;
      brownout_sleep_disable_enable_age_ff <= 3'h0;
    end else if (wr_take && s_axi_wstrb[0] && (wr_idx == `SPR_IDX_BOD_CTRL)
                 && wbyte[`SPR_BROWNOUT_SLEEP_DISABLE_BIT] && wbyte[`SPR_BROWNOUT_SLEEP_DISABLE_ENABLE_BIT]) begin
      brownout_sleep_disable_enable_ff     <= 1'b1;                                             // see R11
      brownout_sleep_disable_enable_age_ff <= 3'h0;
    end else if (brownout_sleep_disable_enable_ff) begin
      brownout_sleep_disable_enable_age_ff <= brownout_sleep_disable_enable_age_ff + 3'h1;
      if (brownout_sleep_disable_enable_age_ff == `SPR_BROWNOUT_SLEEP_DISABLE_ENABLE_WIN_CYC - 3'h1) begin
        brownout_sleep_disable_enable_ff <= 1'b0;                                               // see R12
      end
    end
  end

  // disable bit only set inside the window; lives six cycles in all
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      brownout_sleep_disable_ff     <= 1'b0;
      brownout_sleep_disable_age_ff <= 3'h0;
    end else if (wr_take && s_axi_wstrb[0] && (wr_idx == `SPR_IDX_BOD_CTRL) && brownout_sleep_disable_enable_ff
                 && wbyte[`SPR_BROWNOUT_SLEEP_DISABLE_BIT] && !wbyte[`SPR_BROWNOUT_SLEEP_DISABLE_ENABLE_BIT]) begin
      brownout_sleep_disable_ff     <= 1'b1;                                              // see R10 R12
      brownout_sleep_disable_age_ff <= 3'h0;
    end else if (brownout_sleep_disable_ff) begin
      brownout_sleep_disable_age_ff <= brownout_sleep_disable_age_ff + 3'h1;
      if (brownout_sleep_disable_age_ff == `SPR_BROWNOUT_SLEEP_DISABLE_LIFE_CYC - 3'h1) begin
        brownout_sleep_disable_ff <= 1'b0;                                                // see R13
      end
    end
  end

  assign brownout_sleep_disable_active = brownout_sleep_disable_ff && (brownout_sleep_disable_age_ff >= `SPR_BROWNOUT_SLEEP_DISABLE_DLY_CYC);  // see R13

  // fuse level comes from the fuse array pins, synchronised first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fuse_meta_ff <= 1'b0;
      fuse_sync_ff <= 1'b0;
    end else begin
      fuse_meta_ff <= bod_fuse_pin;
      fuse_sync_ff <= fuse_meta_ff;
    end
  end

  // ------------------------------------------------------------
  // sleep sequencer
  // ------------------------------------------------------------
  // start-up length by mode; detector restart dominates if it was off
  always_comb begin
    start_cyc = 16'h0000;
    if (bod_sw_off_ff) begin
      start_cyc = 16'(BOD_WAKE_CYC);
    end else begin
      case (mode_lat_ff)
        SPR_MODE_IDLE: start_cyc = 16'h0000;
        SPR_MODE_STBY: start_cyc = 16'(`SPR_STBY_WAKE_CYC);           // see R24
        default:       start_cyc = 16'(PDOWN_START_CYC);
      endcase
    end
  end

  // state, latched mode and wait counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff    <= SPR_ST_ACTIVE;
      mode_lat_ff <= SPR_MODE_IDLE;
      cnt_ff      <= 16'h0000;
    end else begin
      case (state_ff)
        SPR_ST_ACTIVE: begin
          if (sleep_instr && sleep_ctrl_ff[1]) begin                    // see R3
            state_ff    <= SPR_ST_SLEEP;
            mode_lat_ff <= cur_mode;                                    // see R1
          end
        end
        SPR_ST_SLEEP: begin
          if (wake_irq) begin
            state_ff <= SPR_ST_WAKE;
            cnt_ff   <= 16'h0000;
          end
        end
        SPR_ST_WAKE: begin
          if (cnt_ff + 16'h0001 >= start_cyc) begin
            state_ff <= SPR_ST_HALT;
            cnt_ff   <= 16'h0000;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        SPR_ST_HALT: begin
          // cpu held four extra cycles before the vector runs
          if (cnt_ff == 16'(`SPR_WAKE_HALT_CYC - 3'h1)) begin          // see R23
            state_ff <= SPR_ST_ACTIVE;
          end else begin
            cnt_ff <= cnt_ff + 16'h0001;
          end
        end
        default: state_ff <= SPR_ST_ACTIVE;
      endcase
    end
  end

  // software detector disable, only for deep modes, dropped when the post-wake halt ends
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bod_sw_off_ff <= 1'b0;
    end else if (state_ff == SPR_ST_ACTIVE && sleep_instr && sleep_ctrl_ff[1]) begin
      bod_sw_off_ff <= brownout_sleep_disable_active && (cur_mode != SPR_MODE_IDLE);      // see R14
    end else if (state_ff == SPR_ST_HALT && cnt_ff == 16'(`SPR_WAKE_HALT_CYC - 3'h1)) begin
      bod_sw_off_ff <= 1'b0;                                            // see R26
    end
  end

  // ------------------------------------------------------------
  // power and clock controls
  // ------------------------------------------------------------
  // io clock stops in deep modes until start-up has passed
  assign deep_sleep = (mode_lat_ff != SPR_MODE_IDLE)
                      && (state_ff == SPR_ST_SLEEP || state_ff == SPR_ST_WAKE);

  always_comb begin
    nxt_pwr            = '0;
    nxt_pwr.acomp_en   = !acomp_disable && !deep_sleep;                 // see R15
    nxt_pwr.bod_en     = fuse_sync_ff
                         && !(bod_sw_off_ff && state_ff == SPR_ST_SLEEP); // back on at wake, see R18 R26
    // reference stays up for a comparator using it even in deep sleep
    nxt_pwr.vref_en    = nxt_pwr.bod_en || (acomp_use_ref && !acomp_disable); // see R16 R17
    nxt_pwr.inbuf_en   = !deep_sleep;                                   // see R20
    nxt_pwr.wakebuf_en = 1'b1;                                          // see R21
    nxt_clk            = '0;
    nxt_clk.cpu_en     = (state_ff == SPR_ST_ACTIVE);
    nxt_clk.io_en      = !deep_sleep;
    nxt_clk.osc_en     = !(deep_sleep && mode_lat_ff != SPR_MODE_STBY);
    // gate enables change only from flops, so the gate cell sees clean edges
    nxt_clk.per_en     = ~pclk_gate_ff & {4{!deep_sleep}};              // see R6 R7 R8 R9 R27
  end

  // registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_ff <= '0;
      clk_ff <= '0;
    end else begin
      pwr_ff <= nxt_pwr;
      clk_ff <= nxt_clk;
    end
  end

  assign pwr_ctrl       = pwr_ff;
  assign clk_ctrl       = clk_ff;
  assign per_reg_access = clk_ff.per_en;                                // see R25
  assign cpu_halt       = (state_ff != SPR_ST_ACTIVE);
  assign wdt_run        = wdt_enable;                                   // see R19

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_bod_start;
    wr_take && s_axi_wstrb[0] && wr_idx == `SPR_IDX_BOD_CTRL
      && wbyte[`SPR_BROWNOUT_SLEEP_DISABLE_BIT] && wbyte[`SPR_BROWNOUT_SLEEP_DISABLE_ENABLE_BIT];
  endsequence

  sequence s_brownout_sleep_disable_set;
    !brownout_sleep_disable_ff ##1 brownout_sleep_disable_ff;
  endsequence

  a_brownout_sleep_disable_lifetime: assert property (@(posedge clk) disable iff (sys_rst) // see R13
    s_brownout_sleep_disable_set |-> !brownout_sleep_disable_active [*3] ##1 brownout_sleep_disable_active [*3] ##1 !brownout_sleep_disable_ff)
    else $error("disable bit timing wrong");

  a_brownout_sleep_disable_enable_window: assert property (@(posedge clk) disable iff (sys_rst) // see R12
    s_bod_start |=> brownout_sleep_disable_enable_ff [*4] ##1 !brownout_sleep_disable_enable_ff)
    else $error("enable window not four cycles");

  a_brownout_sleep_disable_needs_en: assert property (@(posedge clk) disable iff (sys_rst) // see R10
    (!brownout_sleep_disable_ff ##1 brownout_sleep_disable_ff) |-> $past(brownout_sleep_disable_enable_ff))
    else $error("disable set without window");

  a_sleep_needs_se: assert property (@(posedge clk) disable iff (sys_rst) // see R3
    (state_ff == SPR_ST_ACTIVE && sleep_instr && !sleep_ctrl_ff[1])
      |=> state_ff == SPR_ST_ACTIVE)
    else $error("slept without enable");

  a_pgate_rsvd: assert property (@(posedge clk) disable iff (sys_rst)   // see R5
    (rd_take && rd_idx == `SPR_IDX_PCLK_GATE) |=> rdata_ff[31:4] == 28'h0)
    else $error("reserved gate bits nonzero");

  a_halt_four: assert property (@(posedge clk) disable iff (sys_rst)    // see R23
    (state_ff == SPR_ST_WAKE ##1 state_ff == SPR_ST_HALT)
      |-> cpu_halt [*4] ##1 !cpu_halt)
    else $error("post start-up halt not four");

  a_stby_wake: assert property (@(posedge clk) disable iff (sys_rst)    // see R24
    (state_ff == SPR_ST_SLEEP && wake_irq && mode_lat_ff == SPR_MODE_STBY
      && !bod_sw_off_ff) |=> (state_ff == SPR_ST_WAKE) [*6] ##1 state_ff == SPR_ST_HALT)
    else $error("standby wake too slow");

  a_acomp_deep: assert property (@(posedge clk) disable iff (sys_rst)   // see R15
    (state_ff == SPR_ST_SLEEP && mode_lat_ff != SPR_MODE_IDLE) |=> !pwr_ctrl.acomp_en)
    else $error("comparator on in deep sleep");

  a_gate_follow: assert property (@(posedge clk) disable iff (sys_rst)  // see R6
    (!deep_sleep && pclk_gate_ff[`SPR_PG_TIM1_BIT]) |=> !clk_ctrl.per_en[`SPR_PG_TIM1_BIT])
    else $error("timer1 clock not gated");

  a_bod_reenable: assert property (@(posedge clk) disable iff (sys_rst) // see R26
    (state_ff == SPR_ST_HALT ##1 state_ff == SPR_ST_ACTIVE) |-> !bod_sw_off_ff)
    else $error("detector not re-enabled");

endmodule : spr_ctrl

`default_nettype wire

// ===== core/spr_defs.svh
/*
  Offsets, field positions, reset values and timing counts of the sleep and
  power reduction controller. Assumes a 200 MHz CPU clock.
*/
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define SPR_IDX_SLEEP_CTRL   8'h05
`define SPR_IDX_PCLK_GATE    8'h06
`define SPR_IDX_BOD_CTRL     8'h07
`define SPR_IDX_STATUS       8'h08

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SPR_SM1_BIT          6
`define SPR_SE_BIT           5
`define SPR_SM0_BIT          4
`define SPR_PG_TIM1_BIT      3
`define SPR_PG_TIM0_BIT      2
`define SPR_PG_USI_BIT       1
`define SPR_PG_UART_BIT      0
`define SPR_BROWNOUT_SLEEP_DISABLE_BIT         1
`define SPR_BROWNOUT_SLEEP_DISABLE_ENABLE_BIT        0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SPR_RST_SLEEP_CTRL   8'h00
`define SPR_RST_PCLK_GATE    4'h0
`define SPR_RST_BOD_CTRL     8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SPR_CLK_NS           5
`define SPR_BROWNOUT_SLEEP_DISABLE_ENABLE_WIN_CYC    3'h4
`define SPR_BROWNOUT_SLEEP_DISABLE_DLY_CYC     3'h3
`define SPR_BROWNOUT_SLEEP_DISABLE_LIFE_CYC    3'h6
`define SPR_STBY_WAKE_CYC    6
`define SPR_WAKE_HALT_CYC    3'h4
`define SPR_BOD_WAKE_NS      60000
`define SPR_PDOWN_START_CYC  1024

`endif

// ===== core/spr_pkg.sv
/*
  Types of the sleep and power reduction controller.
  Assumes spr_defs.svh for the numbers.
*/
package spr_pkg;

  // sleep mode field encoding
  typedef enum logic [1:0] {
    SPR_MODE_IDLE  = 2'h0,
    SPR_MODE_PDOWN = 2'h1,
    SPR_MODE_STBY  = 2'h2,
    SPR_MODE_PDWN2 = 2'h3
  } spr_mode_t;

  // sleep sequencer, gray along active-sleep-wake-halt
  typedef enum logic [1:0] {
    SPR_ST_ACTIVE = 2'h0,
    SPR_ST_SLEEP  = 2'h1,
    SPR_ST_WAKE   = 2'h3,
    SPR_ST_HALT   = 2'h2
  } spr_state_t;

  // analog and pad power controls
  typedef struct packed {
    logic acomp_en;
    logic vref_en;
    logic bod_en;
    logic inbuf_en;
    logic wakebuf_en;
  } spr_pwr_t;

  // clock enables towards the clock tree
  typedef struct packed {
    logic       cpu_en;
    logic       io_en;
    logic       osc_en;
    logic [3:0] per_en;
  } spr_clk_t;

endpackage : spr_pkg

// ===== tb/spr_ctrl_tb_top.sv
/*
  Self-checking bench for spr_ctrl: register access, clock gating, sleep
  modes, wake timing and the brown-out sleep-disable sequence.
  Assumes spr_defs.svh on the include path and a 200 MHz clock.
*/
`include "spr_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module spr_ctrl_tb_top
  import spr_pkg::*;
;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic        clk, sys_rst, sleep_instr, wake_irq, bod_fuse_pin, cpu_halt;
  logic        acomp_disable, acomp_use_ref, wdt_enable, wdt_run;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br, r;
  logic [3:0]  s_axi_wstrb, per_reg_access;
  logic [7:0]  v;
  spr_pwr_t    pwr_ctrl;
  spr_clk_t    clk_ctrl;
  int          err_total, checks, n, w;
  localparam logic [31:0] adr_sc = `SPR_IDX_SLEEP_CTRL * 4;
  localparam logic [31:0] adr_pg = `SPR_IDX_PCLK_GATE * 4;
  localparam logic [31:0] adr_bc = `SPR_IDX_BOD_CTRL * 4;

  // short start-up counts keep the run brief
  spr_ctrl #(.PDOWN_START_CYC(8), .BOD_WAKE_CYC(20)) spr_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_instr(sleep_instr), .wake_irq(wake_irq),
    .cpu_halt(cpu_halt), .bod_fuse_pin(bod_fuse_pin), .acomp_disable(acomp_disable),
    .acomp_use_ref(acomp_use_ref), .wdt_enable(wdt_enable), .wdt_run(wdt_run),
    .pwr_ctrl(pwr_ctrl), .clk_ctrl(clk_ctrl), .per_reg_access(per_reg_access)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // bready and rready stay high, so a back-to-back call never re-drives them
  // address and data offered together, each dropped once its own ready is seen
  task automatic wr(input logic [31:0] a, input logic [7:0] dat);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge clk);
      if (aw_open && s_axi_awready === 1'b1) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle sleep pulse, then let the registered outputs settle
  task automatic nap();
    @(posedge clk);
    sleep_instr <= 1'b1;
    @(posedge clk);
    sleep_instr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : nap

  // wake pulse; n counts edges until the cpu runs again
  task automatic wk();
    @(posedge clk);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    n = 1;
    while (cpu_halt !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : wk

  // start-up cycles expected per mode; idle still spends one cycle waking
  function automatic int start_of(input int m);
    return (m == 0) ? 1 : (m == 2) ? `SPR_STBY_WAKE_CYC : 8;
  endfunction : start_of

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is a few hundred cycles; this span is generous
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial begin
    {sleep_instr, wake_irq, acomp_disable, acomp_use_ref, wdt_enable} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {sys_rst, bod_fuse_pin} = 2'h3;
    err_total = 0;
    checks = 0;
    void'($urandom(49));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(adr_sc);
    chk(d, 32'h0);
    rd(adr_bc);
    chk(d, 32'h0);
    rd(32'h40);
    chk(d, 32'h0);
    chk(r, 2'h2);
    wr(32'h44, 8'h5A);
    chk(br, 2'h2);
    $display("reset values and map done");
    // corner values first, then random gate patterns
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hF0 : (i == 1) ? 8'h0F : 8'($urandom);
      wr(adr_pg, v);
      rd(adr_pg);
      chk(d, {28'h0, v[3:0]});
      chk(clk_ctrl.per_en, 4'(~v[3:0]));
      chk(per_reg_access, 4'(~v[3:0]));
    end
    wr(adr_pg, 8'h00);
    // a write without byte strobe must leave the gate bits alone
    s_axi_wstrb <= 4'h0;
    wr(adr_pg, 8'h0F);
    s_axi_wstrb <= 4'hF;
    rd(adr_pg);
    chk(d, 32'h0);
    $display("clock gating done");
    wr(adr_sc, 8'h10);
    nap();
    chk(cpu_halt, 1'b0);
    // standby (m == 2) stands for a crystal-clocked part
    // analog pins' digital buffers live outside this block, kept off
    for (int m = 0; m < 4; m++) begin
      wdt_enable <= 1'($urandom);
      wr(adr_sc, {1'b0, m[1], 1'b1, m[0], 4'h0});
      nap();
      chk(cpu_halt, 1'b1);
      chk(clk_ctrl.osc_en, m == 0 || m == 2);
      chk(pwr_ctrl.acomp_en, m == 0);
      chk(pwr_ctrl.inbuf_en, m == 0);
      chk(clk_ctrl.io_en, m == 0);
      chk(clk_ctrl.cpu_en, 1'b0);
      chk(pwr_ctrl.wakebuf_en, 1'b1);
      chk(wdt_run, wdt_enable);
      chk(pwr_ctrl.bod_en, 1'b1);
      wk();
      w = start_of(m);
      chk(n >= w + 4 && n <= w + 6, 1'b1);
      wr(adr_sc, 8'h00);
    end
    $display("sleep modes done");
    // disable bit written alone must be refused
    wr(adr_bc, 8'h02);
    wr(adr_sc, 8'h30);
    nap();
    chk(pwr_ctrl.bod_en, 1'b1);
    wk();
    acomp_use_ref <= 1'b1;
    wr(adr_bc, 8'h03);
    wr(adr_bc, 8'h02);
    @(posedge clk);
    nap();
    chk(pwr_ctrl.bod_en, 1'b0);
    chk(pwr_ctrl.vref_en, 1'b1);
    wk();
    chk(n >= 24 && n <= 26, 1'b1);
    repeat (2) @(posedge clk);
    chk(pwr_ctrl.bod_en, 1'b1);
    rd(adr_bc);
    chk(d, 32'h0);
    acomp_disable <= 1'b1;
    bod_fuse_pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pwr_ctrl.vref_en, 1'b0);
    chk(pwr_ctrl.bod_en, 1'b0);
    chk(pwr_ctrl.acomp_en, 1'b0);
    $display("brown-out sequence done");
    give_verdict();
  end
endmodule : spr_ctrl_tb_top

`default_nettype wire
